// ==== analog_diag_map.svh ====
// Offsets, field positions, reset values and timing figures of the analog diagnostic block
`ifndef ANALOG_DIAG_MAP_SVH
`define ANALOG_DIAG_MAP_SVH

// Read areas
`define AREA_INPUT 1'b0
`define AREA_DIAG 1'b1

// Input area byte offsets, one 2-byte slot per channel
`define OFS_VAL_CH0 5'h00
`define OFS_VAL_CH1 5'h02
`define OFS_VAL_CH3 5'h06
`define OFS_VAL_END 5'h07

// Diagnostic record byte offsets
`define OFS_BITS_PER_CH 5'h05
`define OFS_CH_COUNT 5'h06
`define OFS_GROUP_ERR 5'h07
`define OFS_CH_ERR0 5'h08
`define OFS_CH_ERR3 5'h0b
`define OFS_RSV_FIRST 5'h0c
`define OFS_RSV_LAST 5'h0f
`define OFS_STAMP_FIRST 5'h10
`define OFS_STAMP_LAST 5'h13

// Constant description bytes
`define RST_BITS_PER_CH 8'h08
`define RST_CH_COUNT 8'h04

// Per-channel error byte fields
`define EB_CFG 0
`define EB_INT_LOST 5
`define EB_UNDER 6
`define EB_OVER 7

// Timing figures
`define CLK_PERIOD_NS 100
`define US_NS 1000
`define BLINK_HALF_NS 250000000

`endif

// ==== analog_diag_pkg.sv ====
// Types shared by the analog diagnostic block
package analog_diag_pkg;

	// Per-channel condition flags from the conversion front end
	typedef struct packed {
		logic over;
		logic under;
		logic int_lost;
		logic cfg_err;
	} chan_flags_t;

	// Indicator drive, one bit per lamp
	typedef struct packed {
		logic [3:0] chan;
		logic fault;
		logic run;
	} led_t;

	// Byte read request from the head controller side
	typedef struct packed {
		logic en;
		logic area;
		logic [4:0] addr;
	} rd_req_t;

endpackage : analog_diag_pkg

// ==== analog_input_diag_status.sv ====
// Diagnostic record, indicators and input area of a four-channel current-input module
`timescale 1ns/1ps
`include "analog_diag_map.svh"

module analog_input_diag_status #(
	parameter int NUM_CH = 4,
	parameter int VAL_W = 16,
	parameter int BLINK_HALF_CYC = `BLINK_HALF_NS / `CLK_PERIOD_NS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Conversion front end
	input wire logic [NUM_CH-1:0] sample_valid,
	input wire logic [NUM_CH*VAL_W-1:0] sample_data,
	input wire analog_diag_pkg::chan_flags_t [NUM_CH-1:0] chan_flags,
	// Module status
	input wire logic bus_comm_ok,
	input wire logic bus_power_ok,
	input wire logic module_error,
	input wire logic config_error,
	input wire logic diag_int_en,
	// Parameterization
	input wire logic param_wr,
	input wire logic param_mains_60hz,
	output logic suppress_60hz_q,
	// Byte read port
	input wire analog_diag_pkg::rd_req_t rd_req,
	output logic [7:0] rd_data_q,
	output logic rd_valid_q,
	// Indicators
	output analog_diag_pkg::led_t led_q
);

	localparam int US_CYC = `US_NS / `CLK_PERIOD_NS;
	localparam int BW = $clog2(BLINK_HALF_CYC + 1);

	logic rst_meta_q;
	logic rst_n;
	logic [7:0] presc_q;
	logic [31:0] us_q;
	logic [31:0] stamp_q;
	logic [VAL_W-1:0] val_q [NUM_CH];
	logic [7:0] eb_q [NUM_CH];
	logic [NUM_CH*4-1:0] err_vec;
	logic [NUM_CH*4-1:0] err_prev_q;
	logic cfg_prev_q;
	logic new_evt;
	logic diag_active;
	logic [BW-1:0] blink_cnt_q;
	logic blink_q;

	// Release reset through two flops so the release is clean on clk
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n <= rst_meta_q;
		end
	end

	// Error byte of one channel; unused field bits stay zero
	function automatic logic [7:0] err_byte(input analog_diag_pkg::chan_flags_t f,
			input logic lost);
		logic [7:0] b;
		b = 8'h00;
		b[`EB_CFG] = f.cfg_err;
		b[`EB_INT_LOST] = lost;
		b[`EB_UNDER] = f.under;
		b[`EB_OVER] = f.over;
		return b;
	endfunction : err_byte

	// Microsecond prescaler and ticker; wraps naturally at 32 bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_q <= 8'h00;
			us_q <= 32'h0000_0000;
		end else if (presc_q == 8'(US_CYC - 1)) begin
			presc_q <= 8'h00;
			us_q <= us_q + 32'h0000_0001;
		end else begin
			presc_q <= presc_q + 8'h01;
		end
	end

	// Analog values, held until the next conversion of that channel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				val_q[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (sample_valid[i]) begin
					val_q[i] <= sample_data[i*VAL_W +: VAL_W];
				end
			end
		end
	end

	// Error bytes; the lost-interrupt bit is sticky until its byte is read
	// A loss reported in the same cycle as the read survives it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				eb_q[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				eb_q[i] <= err_byte(chan_flags[i], chan_flags[i].int_lost |
					(eb_q[i][`EB_INT_LOST] & ~(rd_req.en && rd_req.area == `AREA_DIAG &&
					rd_req.addr == `OFS_CH_ERR0 + 5'(i))));
			end
		end
	end

	// Flatten the live error fields to spot newly arrived conditions
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			err_vec[i*4 +: 4] = {eb_q[i][7:5], eb_q[i][0]};
		end
	end

	assign new_evt = (|(err_vec & ~err_prev_q)) | (config_error & ~cfg_prev_q);
	assign diag_active = (|err_vec) | config_error;

	// Timestamp of the most recent incoming diagnostic event
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_prev_q <= '0;
			cfg_prev_q <= 1'b0;
			stamp_q <= 32'h0000_0000;
		end else begin
			err_prev_q <= err_vec;
			cfg_prev_q <= config_error;
			if (new_evt) begin
				stamp_q <= us_q;
			end
		end
	end

	// Half-period counter for the blink; restarts lit on each new configuration error
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt_q <= '0;
			blink_q <= 1'b1;
		end else if (!config_error) begin
			blink_cnt_q <= '0;
			blink_q <= 1'b1;
		end else if (blink_cnt_q == BW'(BLINK_HALF_CYC - 1)) begin
			blink_cnt_q <= '0;
			blink_q <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + BW'(1);
		end
	end

	// Indicators; a dead bus supply darkens everything
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			led_q <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				led_q.chan[i] <= bus_power_ok & (eb_q[i][`EB_CFG] | eb_q[i][`EB_UNDER] |
					eb_q[i][`EB_OVER]);
			end
			if (!bus_power_ok) begin
				led_q.run <= 1'b0;
				led_q.fault <= 1'b0;
			end else if (config_error) begin
				led_q.run <= bus_comm_ok;
				led_q.fault <= blink_q;
			end else if (!bus_comm_ok) begin
				led_q.run <= 1'b0;
				led_q.fault <= 1'b1;
			end else begin
				led_q.run <= 1'b1;
				led_q.fault <= module_error | (diag_int_en & diag_active);
			end
		end
	end

	// Interference suppression choice handed to the conversion front end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			suppress_60hz_q <= 1'b0;
		end else if (param_wr) begin
			suppress_60hz_q <= param_mains_60hz;
		end
	end

	// Read decode; only input area and diagnostic record exist, no output area
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_req.en;
			rd_data_q <= 8'h00;
			if (!rd_req.en) begin
				rd_data_q <= 8'h00;
			end else if (rd_req.area == `AREA_INPUT) begin
				if (rd_req.addr <= `OFS_VAL_END) begin
					rd_data_q <= val_q[rd_req.addr[2:1]][{rd_req.addr[0], 3'b000} +: 8];
				end
			end else if (rd_req.addr == `OFS_BITS_PER_CH) begin
				rd_data_q <= `RST_BITS_PER_CH;
			end else if (rd_req.addr == `OFS_CH_COUNT) begin
				rd_data_q <= `RST_CH_COUNT;
			end else if (rd_req.addr == `OFS_GROUP_ERR) begin
				for (int i = 0; i < NUM_CH; i++) begin
					rd_data_q[i] <= |eb_q[i];
				end
			end else if (rd_req.addr >= `OFS_CH_ERR0 && rd_req.addr <= `OFS_CH_ERR3) begin
				rd_data_q <= eb_q[rd_req.addr[1:0]];
			end else if (rd_req.addr >= `OFS_RSV_FIRST && rd_req.addr <= `OFS_RSV_LAST) begin
				rd_data_q <= 8'h00;
			end else if (rd_req.addr >= `OFS_STAMP_FIRST && rd_req.addr <= `OFS_STAMP_LAST) begin
				rd_data_q <= stamp_q[{rd_req.addr[1:0], 3'b000} +: 8];
			end
		end
	end

	// Checks and coverage
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	function automatic logic diag_rd(input analog_diag_pkg::rd_req_t r, input logic [4:0] a);
		return r.en && r.area == `AREA_DIAG && r.addr == a;
	endfunction : diag_rd

	property p_bits_per_ch;
		diag_rd(rd_req, `OFS_BITS_PER_CH) |=> rd_valid_q && rd_data_q == 8'h08;
	endproperty
	a_bits_per_ch: assert property (p_bits_per_ch) else $error("bits-per-channel byte wrong");

	property p_ch_count;
		diag_rd(rd_req, `OFS_CH_COUNT) |=> rd_data_q == 8'h04;
	endproperty
	a_ch_count: assert property (p_ch_count) else $error("channel-count byte wrong");

	property p_group_err;
		diag_rd(rd_req, `OFS_GROUP_ERR) |=> rd_data_q[7:4] == 4'h0 &&
			rd_data_q[0] == $past(|eb_q[0]);
	endproperty
	a_group_err: assert property (p_group_err) else $error("group error byte wrong");

	property p_cfg_bit;
		chan_flags[0].cfg_err |=> eb_q[0][`EB_CFG] && eb_q[0][4:1] == 4'h0;
	endproperty
	a_cfg_bit: assert property (p_cfg_bit) else $error("config bit not set");

	property p_lost_sticky;
		chan_flags[1].int_lost ##1 (!diag_rd(rd_req, `OFS_CH_ERR0 + 5'h01))[*2]
			|-> eb_q[1][`EB_INT_LOST];
	endproperty
	a_lost_sticky: assert property (p_lost_sticky) else $error("lost bit dropped");

	property p_range;
		chan_flags[2].over && !chan_flags[2].under |=> eb_q[2][7:6] == 2'b10;
	endproperty
	a_range: assert property (p_range) else $error("range bits wrong");

	property p_ticker;
		presc_q == 8'(US_CYC - 1) |=> us_q == $past(us_q) + 32'h1 ##1 us_q == $past(us_q);
	endproperty
	a_ticker: assert property (p_ticker) else $error("ticker step wrong");

	property p_stamp;
		new_evt |=> stamp_q == $past(us_q);
	endproperty
	a_stamp: assert property (p_stamp) else $error("timestamp not captured");

	property p_power_off;
		!bus_power_ok |=> !led_q.run && !led_q.fault && led_q.chan == 4'h0;
	endproperty
	a_power_off: assert property (p_power_off) else $error("lamps lit without power");

	property p_comm_fail;
		bus_power_ok && !bus_comm_ok && !config_error |=> !led_q.run && led_q.fault;
	endproperty
	a_comm_fail: assert property (p_comm_fail) else $error("comm fail lamps wrong");

	property p_run_ok;
		bus_power_ok && bus_comm_ok && !config_error && !module_error && !diag_active
			|=> led_q.run && !led_q.fault;
	endproperty
	a_run_ok: assert property (p_run_ok) else $error("healthy lamps wrong");

	property p_reserved;
		rd_req.en && rd_req.area == `AREA_DIAG && rd_req.addr >= `OFS_RSV_FIRST &&
			rd_req.addr <= `OFS_RSV_LAST |=> rd_data_q == 8'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved byte not zero");

	property p_module_err;
		bus_power_ok && bus_comm_ok && !config_error && module_error
			|=> led_q.run && led_q.fault;
	endproperty
	a_module_err: assert property (p_module_err) else $error("error lamps wrong");

	property p_diag_window;
		bus_power_ok && bus_comm_ok && !config_error && diag_int_en && diag_active
			|=> led_q.fault;
	endproperty
	a_diag_window: assert property (p_diag_window) else $error("window lamp dark");

	property p_chan_lamp;
		bus_power_ok && eb_q[2][`EB_OVER] |=> led_q.chan[2];
	endproperty
	a_chan_lamp: assert property (p_chan_lamp) else $error("channel lamp dark");

	// A dropped and re-raised error restarts the blink, so that cycle is exempt
	property p_blink_half;
		config_error && $changed(blink_q) |=>
			(!config_error || !$past(config_error) || $stable(blink_q))[*7];
	endproperty
	a_blink_half: assert property (p_blink_half) else $error("blink half period short");

	property p_val_byte;
		rd_req.en && rd_req.area == `AREA_INPUT && rd_req.addr == `OFS_VAL_CH1
			|=> rd_data_q == $past(val_q[1][7:0]);
	endproperty
	a_val_byte: assert property (p_val_byte) else $error("channel 1 low byte wrong");

	property p_input_gap;
		rd_req.en && rd_req.area == `AREA_INPUT && rd_req.addr > `OFS_VAL_END
			|=> rd_data_q == 8'h00;
	endproperty
	a_input_gap: assert property (p_input_gap) else $error("input gap not zero");

	c_stamp_read: cover property (new_evt ##[1:20] diag_rd(rd_req, `OFS_STAMP_FIRST));
	c_blink: cover property (config_error && blink_q ##1 !blink_q);
	c_lost_clear: cover property (eb_q[0][`EB_INT_LOST] ##1 !eb_q[0][`EB_INT_LOST]);
	c_comm_fail: cover property (led_q.run ##1 !led_q.run && led_q.fault);

endmodule : analog_input_diag_status

// ==== head_reader.sv ====
// Head controller model that issues byte reads on the read port
`timescale 1ns/1ps

module head_reader (
	// Clock
	input wire logic clk,
	// Read port
	output analog_diag_pkg::rd_req_t rd_req,
	input wire logic [7:0] rd_data_q,
	input wire logic rd_valid_q
);
	// Idle until the bench asks for a byte
	initial rd_req = '0;

	// One byte per request; the answer is taken one cycle later
	task automatic rd(input logic area, input logic [4:0] addr, output logic [7:0] d,
		output logic ok);
		@(negedge clk);
		rd_req <= {1'b1, area, addr};
		@(negedge clk);
		// Idle address is inverted so a stale value never passes for a live one
		rd_req <= {1'b0, area, ~addr};
		d = rd_data_q;
		ok = rd_valid_q;
	endtask : rd
endmodule : head_reader

// ==== tb_top.sv ====
// Self-checking bench for the analog diagnostic block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %h, expected %h", $time, g, e); end end

module tb_top;
	localparam logic [63:0] VALS = 64'h7081_5e6f_3c4d_1a2b;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] sample_valid = '0;
	logic [63:0] sample_data = '0;
	analog_diag_pkg::chan_flags_t [3:0] chan_flags = '0;
	logic bus_comm_ok = 1'b1;
	logic bus_power_ok = 1'b1;
	logic module_error = 1'b0;
	logic config_error = 1'b0;
	logic diag_int_en = 1'b0;
	logic param_wr = 1'b0;
	logic param_mains_60hz = 1'b0;
	logic suppress_60hz_q;
	analog_diag_pkg::rd_req_t rd_req;
	logic [7:0] rd_data_q;
	logic rd_valid_q;
	analog_diag_pkg::led_t led_q;
	int n_errors = 0;
	int n_compared = 0;
	logic [31:0] s0;
	logic [31:0] s1;

	// 10 MHz clock
	always #50 clk = ~clk;

	// Short blink period keeps the lamp scenario brief
	analog_input_diag_status #(.BLINK_HALF_CYC(8)) dut (.clk(clk), .reset_n(reset_n),
		.sample_valid(sample_valid), .sample_data(sample_data), .chan_flags(chan_flags),
		.bus_comm_ok(bus_comm_ok), .bus_power_ok(bus_power_ok),
		.module_error(module_error), .config_error(config_error),
		.diag_int_en(diag_int_en), .param_wr(param_wr),
		.param_mains_60hz(param_mains_60hz), .suppress_60hz_q(suppress_60hz_q),
		.rd_req(rd_req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .led_q(led_q));

	head_reader host (.clk(clk), .rd_req(rd_req), .rd_data_q(rd_data_q),
		.rd_valid_q(rd_valid_q));

	// Print counts and verdict, then stop
	task automatic conclude();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	// Read one byte and compare it
	task automatic cb(input logic area, input logic [4:0] addr, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		host.rd(area, addr, d, ok);
		`CHK(ok, 1'b1)
		`CHK(d, e)
	endtask : cb

	// Gather the four timestamp bytes, low byte first
	task automatic stamp(output logic [31:0] s);
		logic [7:0] d;
		logic ok;
		for (int i = 0; i < 4; i++) begin
			host.rd(1'b1, 5'h10 + 5'(i), d, ok);
			s[8*i +: 8] = d;
		end
	endtask : stamp

	// Two events exactly 100 cycles apart must differ by ten ticks
	task automatic t_stamp();
		@(negedge clk);
		config_error = 1'b1;
		stamp(s0);
		@(negedge clk);
		config_error = 1'b0;
		repeat (91) @(negedge clk);
		config_error = 1'b1;
		stamp(s1);
		config_error = 1'b0;
		`CHK(s0, 32'h0000_0000)
		`CHK(s1 - s0, 32'h0000_000a)
	endtask : t_stamp

	// Description bytes, reserved bytes and an unmapped place
	task automatic t_consts();
		cb(1'b1, 5'h05, 8'h08);
		cb(1'b1, 5'h06, 8'h04);
		for (int i = 0; i < 4; i++) begin
			cb(1'b1, 5'h0c + 5'(i), 8'h00);
		end
		cb(1'b1, 5'h00, 8'h00);
		cb(1'b1, 5'h07, 8'h00);
	endtask : t_consts

	// Channel error bytes, sticky lost bit and channel lamps
	task automatic t_chan();
		@(negedge clk);
		chan_flags[2] = 4'b1101;
		chan_flags[1].int_lost = 1'b1;
		@(negedge clk);
		chan_flags[1].int_lost = 1'b0;
		@(negedge clk);
		`CHK(led_q.chan, 4'b0100)
		`CHK({led_q.run, led_q.fault}, 2'b10)
		cb(1'b1, 5'h0a, 8'hc1);
		cb(1'b1, 5'h07, 8'h06);
		cb(1'b1, 5'h09, 8'h20);
		cb(1'b1, 5'h09, 8'h00);
		diag_int_en = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(led_q.fault, 1'b1)
		chan_flags = '0;
		chan_flags[0].cfg_err = 1'b1;
		diag_int_en = 1'b0;
		cb(1'b1, 5'h08, 8'h01);
		chan_flags = '0;
	endtask : t_chan

	// Apply a bus state and compare run and fault lamps
	task automatic lamp(input logic p, input logic c, input logic m, input logic [1:0] e);
		@(negedge clk);
		bus_power_ok = p;
		bus_comm_ok = c;
		module_error = m;
		repeat (2) @(negedge clk);
		`CHK({led_q.run, led_q.fault}, e)
	endtask : lamp

	// Lamp states, then blinking on a configuration error while communication is down
	task automatic t_lamps();
		lamp(1'b1, 1'b1, 1'b0, 2'b10);
		lamp(1'b1, 1'b1, 1'b1, 2'b11);
		lamp(1'b1, 1'b0, 1'b0, 2'b01);
		lamp(1'b0, 1'b1, 1'b0, 2'b00);
		lamp(1'b1, 1'b0, 1'b0, 2'b01);
		config_error = 1'b1;
		repeat (3) @(negedge clk);
		`CHK({led_q.run, led_q.fault}, 2'b01)
		repeat (8) @(negedge clk);
		`CHK({led_q.run, led_q.fault}, 2'b00)
		config_error = 1'b0;
		bus_comm_ok = 1'b1;
	endtask : t_lamps

	// Captured values read back byte by byte; data changed after the pulse
	task automatic t_samples();
		@(negedge clk);
		sample_data = VALS;
		sample_valid = 4'hf;
		@(negedge clk);
		sample_valid = 4'h0;
		sample_data = ~VALS;
		for (int i = 0; i < 8; i++) begin
			cb(1'b0, 5'(i), VALS[8*i +: 8]);
		end
		cb(1'b0, 5'h08, 8'h00);
	endtask : t_samples

	// Mains selection loads on the write pulse only
	task automatic t_param();
		param_mains_60hz = 1'b1;
		param_wr = 1'b1;
		@(negedge clk);
		param_wr = 1'b0;
		param_mains_60hz = 1'b0;
		@(negedge clk);
		`CHK(suppress_60hz_q, 1'b1)
		param_wr = 1'b1;
		@(negedge clk);
		param_wr = 1'b0;
		@(negedge clk);
		`CHK(suppress_60hz_q, 1'b0)
	endtask : t_param

	// Main sequence
	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		t_stamp();
		t_consts();
		t_chan();
		t_lamps();
		t_samples();
		t_param();
		conclude();
	end

	// Watchdog well beyond the few hundred cycles the run needs
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		conclude();
	end
endmodule : tb_top
